// ==== isi_pkg.sv ====
package isi_pkg;

    // register map (word aligned)
    localparam logic [7:0] ISI_CTRL_ADDR = 8'h00;
    localparam logic [7:0] ISI_COND_ADDR = 8'h04;
    localparam logic [7:0] ISI_STAT_ADDR = 8'h08;
    localparam logic [7:0] ISI_LONG_ADDR = 8'h0C;
    localparam logic [7:0] ISI_SHRT_ADDR = 8'h10;

    // control register fields
    localparam int ISI_CTRL_SRC_BIT = 0;
    localparam int ISI_CTRL_RST_BIT = 1;

    // flash half periods: long 500 ms, short 125 ms at 200 MHz
    localparam int ISI_CLK_MHZ = 200;
    localparam int ISI_LONG_MS = 500;
    localparam int ISI_SHORT_MS = 125;
    localparam int ISI_LONG_CYC = ISI_LONG_MS * 1000 * ISI_CLK_MHZ;
    localparam int ISI_SHORT_CYC = ISI_SHORT_MS * 1000 * ISI_CLK_MHZ;

    // lamp pattern codes
    typedef enum logic [1:0] {
        ISI_OFF = 2'h0,
        ISI_ON = 2'h1,
        ISI_FLASH = 2'h2,
        ISI_LFLASH = 2'h3
    } isi_lamp_type;

    // condition inputs gathered together
    typedef struct packed {
        logic ready;
        logic faultIn;
        logic eStopAlarm;
        logic eStopFault;
        logic alarm;
        logic baseblock;
        logic running;
        logic decel;
        logic runCmd;
        logic stopped;
    } isi_cond_type;

    // keypad and terminal commands
    typedef struct packed {
        logic keyStop;
        logic termReset;
    } isi_cmd_type;

    localparam int ISI_COND_W = $bits(isi_cond_type);

endpackage : isi_pkg

// ==== isi_flash_div.sv ====
`timescale 1ns/100ps
// free running divider making long and short flash phases
module isi_flash_div (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // half periods in cycles
    input wire logic [31:0] longHalf,
    input wire logic [31:0] shortHalf,
    // flash phases
    output logic longPhase,
    output logic shortPhase
);
    import isi_pkg::*;

    logic [31:0] longCnt_q;
    logic [31:0] shortCnt_q;

    // long flash counter
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            longCnt_q <= 32'h0;
            longPhase <= 1'b0;
        end else if (longCnt_q + 32'h1 >= longHalf) begin
            longCnt_q <= 32'h0;
            longPhase <= ~longPhase;
        end else begin
            longCnt_q <= longCnt_q + 32'h1;
        end
    end

    // short flash counter
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shortCnt_q <= 32'h0;
            shortPhase <= 1'b0;
        end else if (shortCnt_q + 32'h1 >= shortHalf) begin
            shortCnt_q <= 32'h0;
            shortPhase <= ~shortPhase;
        end else begin
            shortCnt_q <= shortCnt_q + 32'h1;
        end
    end
endmodule : isi_flash_div

// ==== isi_status_lamps.sv ====
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
module isi_status_lamps #(
    parameter logic [31:0] LONG_HALF = 32'(isi_pkg::ISI_LONG_CYC),
    parameter logic [31:0] SHORT_HALF = 32'(isi_pkg::ISI_SHORT_CYC)
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // condition and command pins
    input wire isi_pkg::isi_cond_type condIn,
    input wire isi_pkg::isi_cmd_type cmdIn,
    // lamps and fault latch
    output logic runLamp,
    output logic alarmLamp,
    output logic keyRunLamp,
    output logic faultLatched
);
    import isi_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // input synchronisers, three stages
    isi_cond_type condS1_q, condS2_q, condS3_q, cond_q;
    isi_cmd_type cmdS1_q, cmdS2_q, cmdS3_q, cmd_q;

    // shift pins through three flops
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            condS1_q <= '0;
            condS2_q <= '0;
            condS3_q <= '0;
            cmdS1_q <= '0;
            cmdS2_q <= '0;
            cmdS3_q <= '0;
        end else begin
            condS1_q <= condIn;
            condS2_q <= condS1_q;
            condS3_q <= condS2_q;
            cmdS1_q <= cmdIn;
            cmdS2_q <= cmdS1_q;
            cmdS3_q <= cmdS2_q;
        end
    end

    // accept a bit once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cond_q <= '0;
            cmd_q <= '0;
        end else begin
            cond_q <= (condS2_q & condS3_q) | (cond_q & (condS2_q | condS3_q));
            cmd_q <= (cmdS2_q & cmdS3_q) | (cmd_q & (cmdS2_q | cmdS3_q));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // ahb-lite register slave
    logic [1:0] ctrl_q; // bit0 run source, bit1 held at zero (software fault reset acts on the write data only)
    logic [31:0] longHalf_q;
    logic [31:0] shortHalf_q;
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic [31:0] readData_d;
    logic [3:0] prio_q;
    logic accept;

    assign accept = hsel && hready && htrans[1];

    // read mux
    always_comb begin
        readData_d = 32'h0;
        case (haddr[7:0])
            ISI_CTRL_ADDR: readData_d = {30'h0, ctrl_q};
            ISI_COND_ADDR: readData_d = 32'(cond_q);
            ISI_STAT_ADDR: readData_d = {23'h0, faultLatched, prio_q,
                1'b0, runLamp, alarmLamp, keyRunLamp};
            ISI_LONG_ADDR: readData_d = longHalf_q;
            ISI_SHRT_ADDR: readData_d = shortHalf_q;
            default: readData_d = 32'h0;
        endcase
    end

    // address phase capture, read data registered
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h0;
            hrdata <= 32'h0;
        end else if (hready) begin
            wrPend_q <= accept && hwrite;
            wrAddr_q <= haddr[7:0];
            hrdata <= (accept && !hwrite) ? readData_d : 32'h0;
        end
    end

    // zero wait state, always okay
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    logic swReset;
    assign swReset = wrPend_q && wrAddr_q == ISI_CTRL_ADDR
        && hwdata[ISI_CTRL_RST_BIT];

    // register writes
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_q <= 2'h0;
            longHalf_q <= LONG_HALF;
            shortHalf_q <= SHORT_HALF;
        end else if (wrPend_q) begin
            case (wrAddr_q)
                ISI_CTRL_ADDR: ctrl_q <= {1'b0, hwdata[ISI_CTRL_SRC_BIT]};
                ISI_LONG_ADDR: longHalf_q <= hwdata;
                ISI_SHRT_ADDR: shortHalf_q <= hwdata;
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flash divider
    logic longPhase, shortPhase;

    isi_flash_div u_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .longHalf(longHalf_q),
        .shortHalf(shortHalf_q),
        .longPhase(longPhase),
        .shortPhase(shortPhase)
    );

    ////////////////////////////////////////////////////////////////////
    // fault latch and emergency stop memory
    logic termSrc;
    logic keyStopEdge;
    logic keyStopLast_q;
    logic faultClr;
    logic eStopA_q; // latched priority 3 stop
    logic eStopF_q; // latched priority 4 stop

    assign termSrc = ctrl_q[ISI_CTRL_SRC_BIT];
    assign keyStopEdge = cmd_q.keyStop && !keyStopLast_q;
    // reset input, stop key edge or software reset, only with run off
    assign faultClr = !cond_q.runCmd
        && (cmd_q.termReset || keyStopEdge || swReset);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            keyStopLast_q <= 1'b0;
        end else begin
            keyStopLast_q <= cmd_q.keyStop;
        end
    end

    // fault latch: a new fault beats a clear, power loss clears
    always_ff @(posedge sys_clk) begin
        if (reset || !cond_q.ready) begin
            faultLatched <= 1'b0;
        end else if (cond_q.faultIn || cond_q.eStopFault) begin
            faultLatched <= 1'b1;
        end else if (faultClr) begin
            faultLatched <= 1'b0;
        end
    end

    // keypad stop under terminal control holds an emergency stop
    always_ff @(posedge sys_clk) begin
        if (reset || !cond_q.ready) begin
            eStopA_q <= 1'b0;
        end else if (termSrc && keyStopEdge) begin
            eStopA_q <= 1'b1;
        end else if (faultClr) begin
            eStopA_q <= 1'b0;
        end
    end

    // estop fault remembered while decelerating
    always_ff @(posedge sys_clk) begin
        if (reset || !cond_q.ready) begin
            eStopF_q <= 1'b0;
        end else if (cond_q.eStopFault) begin
            eStopF_q <= 1'b1;
        end else if (faultClr) begin
            eStopF_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // priority selection
    function automatic logic [3:0] pickPrio(input isi_cond_type c,
        input logic fLat, input logic eA, input logic eF);
        logic eStopA;
        logic eStopF;
        eStopA = (eA || c.eStopAlarm) && !c.stopped;
        eStopF = (eF || c.eStopFault) && !c.stopped;
        if (!c.ready) pickPrio = 4'h1;
        else if (eStopF) pickPrio = 4'h4;
        else if (fLat) pickPrio = 4'h2;
        else if (eStopA) pickPrio = 4'h3;
        else if ((c.alarm || eA || c.eStopAlarm) && c.stopped)
            pickPrio = 4'h5;
        else if (c.alarm || (c.runCmd && c.baseblock))
            pickPrio = 4'h6;
        else if (c.baseblock && c.stopped) pickPrio = 4'h7;
        else if (c.running) pickPrio = 4'h8;
        else if (c.decel) pickPrio = 4'h9;
        else pickPrio = 4'h0;
    endfunction : pickPrio

    // pattern pair for a priority, run in high bits
    function automatic logic [3:0] prioPattern(input logic [3:0] p);
        case (p)
            4'h1: prioPattern = {ISI_OFF, ISI_OFF};
            4'h2: prioPattern = {ISI_OFF, ISI_ON};
            4'h3: prioPattern = {ISI_FLASH, ISI_FLASH};
            4'h4: prioPattern = {ISI_FLASH, ISI_ON};
            4'h5: prioPattern = {ISI_LFLASH, ISI_LFLASH};
            4'h6: prioPattern = {ISI_ON, ISI_FLASH};
            4'h7: prioPattern = {ISI_LFLASH, ISI_OFF};
            4'h8: prioPattern = {ISI_ON, ISI_OFF};
            4'h9: prioPattern = {ISI_FLASH, ISI_OFF};
            default: prioPattern = {ISI_LFLASH, ISI_OFF}; // idle stop
        endcase
    endfunction : prioPattern

    // pattern to lamp level
    function automatic logic lampLevel(input logic [1:0] pat,
        input logic lp, input logic sp);
        case (pat)
            ISI_ON: lampLevel = 1'b1;
            ISI_FLASH: lampLevel = sp;
            ISI_LFLASH: lampLevel = lp;
            default: lampLevel = 1'b0;
        endcase
    endfunction : lampLevel

    logic [3:0] pat;
    assign pat = prioPattern(prio_q);

    // registered priority
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prio_q <= 4'h1;
        end else begin
            prio_q <= pickPrio(cond_q, faultLatched, eStopA_q,
                eStopF_q);
        end
    end

    // lamp outputs, key lamp mirrors face run lamp
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            runLamp <= 1'b0;
            keyRunLamp <= 1'b0;
            alarmLamp <= 1'b0;
        end else begin
            runLamp <= lampLevel(pat[3:2], longPhase, shortPhase);
            keyRunLamp <= lampLevel(pat[3:2], longPhase, shortPhase);
            alarmLamp <= lampLevel(pat[1:0], longPhase, shortPhase);
        end
    end
endmodule : isi_status_lamps

// ==== isi_status_lamps_asserts.sv ====
`timescale 1ns/100ps
// watches lamp, latch and bus outputs against the pin levels
module isi_status_lamps_asserts import isi_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // pins and outputs
    input wire isi_pkg::isi_cond_type condIn,
    input wire isi_pkg::isi_cmd_type cmdIn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic runLamp,
    input wire logic alarmLamp,
    input wire logic keyRunLamp,
    input wire logic faultLatched
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////
    // step sequences, long enough to cover sync plus priority latency
    sequence s_unpowered;
        (!condIn.ready && !condIn.faultIn && !condIn.eStopFault)[*8];
    endsequence
    sequence s_fault_in;
        (condIn.faultIn && condIn.ready)[*7];
    endsequence
    sequence s_run_hold;
        (faultLatched && condIn.runCmd && condIn.ready)[*6];
    endsequence
    sequence s_reset_req;
        (cmdIn.termReset && !condIn.runCmd && !condIn.faultIn
            && !condIn.eStopFault)[*8];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_key_mirror: assert property (keyRunLamp == runLamp)
        else $error("key run lamp differs from run lamp");
    a_dark_lamps: assert property (s_unpowered |-> !runLamp && !alarmLamp)
        else $error("lamps lit without power ready");
    a_power_clear: assert property (s_unpowered |-> !faultLatched)
        else $error("fault kept through power loss");
    a_fault_set: assert property (s_fault_in |-> faultLatched)
        else $error("fault input not latched");
    a_fault_lamps: assert property ((faultLatched && condIn.ready
        && !condIn.eStopFault)[*8] |-> alarmLamp && !runLamp)
        else $error("fault lamp pattern wrong");
    a_fault_hold: assert property (s_run_hold |=> faultLatched)
        else $error("fault cleared while run command on");
    a_fault_clear: assert property (s_reset_req |-> !faultLatched)
        else $error("fault reset input did not clear fault");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or answered error");
endmodule : isi_status_lamps_asserts

bind isi_status_lamps isi_status_lamps_asserts u_isi_status_lamps_asserts (
    .sys_clk(sys_clk), .reset(reset), .condIn(condIn), .cmdIn(cmdIn),
    .hreadyout(hreadyout), .hresp(hresp), .runLamp(runLamp),
    .alarmLamp(alarmLamp), .keyRunLamp(keyRunLamp),
    .faultLatched(faultLatched));

// ==== isi_panel_model.sv ====
`timescale 1ns/100ps
// keypad keys and terminal contacts, switched just after a clock edge
module isi_panel_model import isi_pkg::*; (
    // clock
    input wire logic sys_clk,
    // wanted levels
    input wire isi_pkg::isi_cond_type condSet,
    input wire isi_pkg::isi_cmd_type cmdSet,
    // pins toward the device
    output isi_pkg::isi_cond_type condIn,
    output isi_pkg::isi_cmd_type cmdIn
);
    // contacts open at power up
    initial begin
        condIn = '0;
        cmdIn = '0;
    end
    // contact levels follow the wanted levels one edge later
    always @(posedge sys_clk) begin
        condIn <= condSet;
        cmdIn <= cmdSet;
    end
endmodule : isi_panel_model

// ==== testbench.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        n_fail++; \
        $display("ERROR t=%0t got %h want %h", $time, a, b); \
    end \
end
module testbench;
    import isi_pkg::*;
    // lamp expectations as {seen lit, seen dark}
    localparam logic [1:0] P_OFF = 2'h1;
    localparam logic [1:0] P_ON = 2'h2;
    localparam logic [1:0] P_FL = 2'h3;
    // rows: conditions, priority, run pattern, alarm pattern
    localparam logic [17:0] TAB [9] = '{
        {10'h000, 4'h1, P_OFF, P_OFF}, {10'h208, 4'h8, P_ON, P_OFF},
        {10'h204, 4'h9, P_FL, P_OFF}, {10'h211, 4'h7, P_FL, P_OFF},
        {10'h228, 4'h6, P_ON, P_FL}, {10'h221, 4'h5, P_FL, P_FL},
        {10'h284, 4'h3, P_FL, P_FL}, {10'h244, 4'h4, P_FL, P_ON},
        {10'h241, 4'h2, P_OFF, P_ON}};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0, hreadyout, hresp;
    logic runLamp, alarmLamp, keyRunLamp, faultLatched;
    isi_cond_type condSet = '0, condIn;
    isi_cmd_type cmdSet = '0, cmdIn;
    int n_fail = 0, samples_checked = 0;

    ////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial forever #2.5 sys_clk = ~sys_clk;
    isi_panel_model u_isi_panel_model (.sys_clk(sys_clk), .condSet(condSet),
        .cmdSet(cmdSet), .condIn(condIn), .cmdIn(cmdIn));
    isi_status_lamps #(.LONG_HALF(32'h4), .SHORT_HALF(32'h2))
        u_isi_status_lamps (.sys_clk(sys_clk), .reset(reset), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .condIn(condIn),
        .cmdIn(cmdIn), .runLamp(runLamp), .alarmLamp(alarmLamp),
        .keyRunLamp(keyRunLamp), .faultLatched(faultLatched));

    ////////////////////////////////////////////////////////////////////////
    // one single ahb transfer, entered just after a rising edge
    task automatic bus(input logic w, input logic [31:0] a, d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // set pin levels, key bits are {stop key, fault reset}
    task automatic pins(input logic [9:0] c, input logic [1:0] k);
        condSet <= c;
        cmdSet <= k;
        @(posedge sys_clk);
    endtask : pins
    // settle, then read the fault latch bit of the status word
    task automatic stat(input logic f);
        repeat (10) @(posedge sys_clk);
        bus(1'b0, 32'(ISI_STAT_ADDR), 32'h0);
        `CHK(rd[8], f)
    endtask : stat
    // apply one row, check priority code and watch both lamps
    task automatic look(input logic [17:0] r);
        logic [1:0] rs, al;
        rs = 2'h0;
        al = 2'h0;
        pins(r[17:8], 2'h0);
        repeat (12) @(posedge sys_clk);
        bus(1'b0, 32'(ISI_STAT_ADDR), 32'h0);
        `CHK(rd[7:4], r[7:4])
        repeat (20) begin
            @(posedge sys_clk);
            #1;
            rs |= {runLamp, !runLamp};
            al |= {alarmLamp, !alarmLamp};
        end
        @(posedge sys_clk);
        `CHK(rs, r[3:2])
        `CHK(al, r[1:0])
    endtask : look
    // verdict and end of run
    task automatic close_out();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, 32'(ISI_CTRL_ADDR), 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b0, 32'h20, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, 32'(ISI_LONG_ADDR), 32'h4);
        bus(1'b1, 32'(ISI_SHRT_ADDR), 32'h2);
        bus(1'b0, 32'(ISI_SHRT_ADDR), 32'h0);
        `CHK(rd, 32'h2)
        foreach (TAB[i]) begin
            look(TAB[i]);
        end
        pins(10'h203, 2'h1);
        stat(1'b1);
        pins(10'h201, 2'h1);
        stat(1'b0);
        pins(10'h301, 2'h0);
        stat(1'b1);
        pins(10'h201, 2'h0);
        // let the fault pin drop through the synchroniser, set beats clear
        repeat (6) @(posedge sys_clk);
        bus(1'b1, 32'(ISI_CTRL_ADDR), 32'h2);
        stat(1'b0);
        pins(10'h301, 2'h0);
        stat(1'b1);
        pins(10'h201, 2'h2);
        stat(1'b0);
        pins(10'h301, 2'h0);
        stat(1'b1);
        pins(10'h000, 2'h0);
        stat(1'b0);
        bus(1'b1, 32'(ISI_CTRL_ADDR), 32'h1);
        pins(10'h208, 2'h2);
        repeat (6) @(posedge sys_clk);
        look({10'h208, 4'h3, P_FL, P_FL});
        look({10'h201, 4'h5, P_FL, P_FL});
        pins(10'h201, 2'h1);
        stat(1'b0);
        bus(1'b0, 32'(ISI_COND_ADDR), 32'h0);
        `CHK(rd, 32'h201)
        close_out();
    end
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        $display("ERROR t=%0t watchdog expired", $time);
        close_out();
    end
endmodule : testbench
